// File: hdl/adc_config_register_map.sv
// serial-port configuration register bank with shadowed function registers
`timescale 1ns/100ps

// What this block does
// RQ1: function registers written into holding copies
// RQ2: writing 0x01 to 0xff applies holding copies
// RQ3: all copied together, transfer bit self-clears
// RQ4: reset reloads every register default
// RQ5: port config 0x18, mirrored nibbles
// RQ6: grade read only, speed code 00
// RQ7: transfer register only bit 0, reset 0x00
// RQ8: power mode 00 normal, 01 power-down
// RQ9: stabilizer enable bit, default on
// RQ10: nonzero divide forces stabilizer on
// RQ11: divider phase delay field, zero to seven
// RQ12: user pattern repeat or single shot
// RQ13: output test mode fixed pattern select
// RQ14: six-bit two's complement offset trim
// RQ15: active-high output disable and invert bit
// RQ16: four-bit output drive current code
// RQ17: output clock delay enable and code
// RQ18: five-bit input span selection code
// RQ19: host ignores unlisted addresses and bits
// RQ20: host writes zero to unused bits
module adc_config_register_map #(
	parameter logic [7:0] DEVICE_ID = 8'h5a // arbitrary identification value
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic sclk,
	input wire logic csb_n,
	input wire logic sdio_in,
	output logic sdio_out,
	output logic sdio_oe_n,
	output logic power_down,
	output logic [2:0] clock_divide_ratio,
	output logic [2:0] divider_phase_delay,
	output logic stabilizer_active,
	output logic user_pattern_single,
	output logic pn_long_reset,
	output logic pn_short_reset,
	output logic [3:0] output_test_mode,
	output logic [5:0] offset_trim,
	output logic output_disable,
	output logic data_invert,
	output logic [1:0] output_format,
	output logic [3:0] drive_current_code,
	output logic output_data_clock_invert,
	output logic output_data_clock_delay_en,
	output logic [4:0] output_data_clock_delay_code,
	output logic [4:0] full_scale_code,
	output logic [15:0] user_pattern_1,
	output logic [15:0] user_pattern_2,
	output logic [15:0] user_pattern_3,
	output logic [15:0] user_pattern_4,
	output logic requant_enable,
	output logic [2:0] requant_mode,
	output logic [5:0] requant_tuning
);
	typedef enum logic {st_instr, st_data} frame_state_t;

	// implemented bits of a shadowed address, zero where none
	function automatic logic [7:0] bank_mask(input logic [12:0] a);
		logic [7:0] m;
		m = 8'h00;
		if (a >= adc_cfg_pkg::ADDR_PATTERN_FIRST && a <= adc_cfg_pkg::ADDR_PATTERN_LAST) begin
			m = adc_cfg_pkg::MASK_PATTERN;
		end
		unique case (a)
			adc_cfg_pkg::ADDR_POWER_MODE: m = adc_cfg_pkg::MASK_POWER_MODE;
			adc_cfg_pkg::ADDR_GLOBAL_CLOCK: m = adc_cfg_pkg::MASK_GLOBAL_CLOCK;
			adc_cfg_pkg::ADDR_CLOCK_DIV: m = adc_cfg_pkg::MASK_CLOCK_DIV;
			adc_cfg_pkg::ADDR_TEST_PATTERN: m = adc_cfg_pkg::MASK_TEST_PATTERN;
			adc_cfg_pkg::ADDR_OFFSET_TRIM: m = adc_cfg_pkg::MASK_OFFSET_TRIM;
			adc_cfg_pkg::ADDR_OUT_FORMAT: m = adc_cfg_pkg::MASK_OUT_FORMAT;
			adc_cfg_pkg::ADDR_OUT_DRIVE: m = adc_cfg_pkg::MASK_OUT_DRIVE;
			adc_cfg_pkg::ADDR_OUT_CLK_PHASE: m = adc_cfg_pkg::MASK_OUT_CLK_PHASE;
			adc_cfg_pkg::ADDR_OUT_CLK_DELAY: m = adc_cfg_pkg::MASK_OUT_CLK_DELAY;
			adc_cfg_pkg::ADDR_INPUT_SPAN: m = adc_cfg_pkg::MASK_INPUT_SPAN;
			adc_cfg_pkg::ADDR_REQ_CONTROL: m = adc_cfg_pkg::MASK_REQ_CONTROL;
			adc_cfg_pkg::ADDR_REQ_TUNING: m = adc_cfg_pkg::MASK_REQ_TUNING;
			default: ;
		endcase
		return m;
	endfunction : bank_mask

	// power-on value of a shadowed address
	function automatic logic [7:0] bank_default(input logic [5:0] i);
		logic [7:0] v;
		v = adc_cfg_pkg::RST_SHADOW;
		if (i == adc_cfg_pkg::ADDR_GLOBAL_CLOCK[5:0]) begin
			v = adc_cfg_pkg::RST_GLOBAL_CLOCK; // RQ9
		end
		if (i == adc_cfg_pkg::ADDR_OUT_FORMAT[5:0]) begin
			v = adc_cfg_pkg::RST_OUT_FORMAT;
		end
		if (i == adc_cfg_pkg::ADDR_REQ_TUNING[5:0]) begin
			v = adc_cfg_pkg::RST_REQ_TUNING;
		end
		return v;
	endfunction : bank_default

	logic [7:0] shadow_reg [0:63];
	logic [7:0] active_reg [0:63];
	logic [7:0] port_cfg_reg;
	logic transfer_reg;
	logic soft_reset_reg;

	logic sclk_meta_reg, sclk_sync_reg, sclk_prev_reg;
	logic csb_meta_reg, csb_sync_reg;
	logic sdio_meta_reg, sdio_sync_reg;

	frame_state_t state_reg;
	logic [4:0] bit_cnt_reg;
	logic [15:0] shift_reg;
	logic [7:0] tx_reg;
	logic [12:0] addr_reg;
	logic is_read_reg;
	logic [1:0] len_reg;
	logic [1:0] byte_cnt_reg;

	logic sclk_rise, sclk_fall, lsb_first;
	logic [15:0] shift_next;
	logic [7:0] rx_byte;
	logic instr_done, byte_done, wr_strobe;
	logic [12:0] addr_next;

	// pin inputs pass two flops before use
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			sclk_meta_reg <= 1'b0;
			sclk_sync_reg <= 1'b0;
			sclk_prev_reg <= 1'b0;
			csb_meta_reg <= 1'b1;
			csb_sync_reg <= 1'b1;
			sdio_meta_reg <= 1'b0;
			sdio_sync_reg <= 1'b0;
		end else begin
			sclk_meta_reg <= sclk;
			sclk_sync_reg <= sclk_meta_reg;
			sclk_prev_reg <= sclk_sync_reg;
			csb_meta_reg <= csb_n;
			csb_sync_reg <= csb_meta_reg;
			sdio_meta_reg <= sdio_in;
			sdio_sync_reg <= sdio_meta_reg;
		end
	end

	assign sclk_rise = !csb_sync_reg && sclk_sync_reg && !sclk_prev_reg;
	assign sclk_fall = !csb_sync_reg && !sclk_sync_reg && sclk_prev_reg;
	assign lsb_first = port_cfg_reg[adc_cfg_pkg::PORT_LSB_HI]; // RQ5

	always_comb begin
		if (lsb_first) begin
			shift_next = {sdio_sync_reg, shift_reg[15:1]};
			rx_byte = shift_next[15:8];
		end else begin
			shift_next = {shift_reg[14:0], sdio_sync_reg};
			rx_byte = shift_next[7:0];
		end
	end

	assign instr_done = sclk_rise && state_reg == st_instr
		&& bit_cnt_reg == 5'(adc_cfg_pkg::INSTR_BITS - 1);
	assign byte_done = sclk_rise && state_reg == st_data && bit_cnt_reg == 5'd7;
	assign wr_strobe = byte_done && !is_read_reg;
	// address runs downward in msb-first mode, upward in lsb-first mode
	assign addr_next = lsb_first ? addr_reg + 13'd1 : addr_reg - 13'd1;

	// read value of any address; unlisted locations read zero
	function automatic logic [7:0] read_value(input logic [12:0] a, input logic [7:0] pcfg,
		input logic xfer, input logic [7:0] sh);
		logic [7:0] v;
		v = sh & bank_mask(a);
		unique case (a)
			adc_cfg_pkg::ADDR_PORT_CFG: v = pcfg;
			adc_cfg_pkg::ADDR_DEV_ID: v = DEVICE_ID;
			adc_cfg_pkg::ADDR_DEV_GRADE: v = adc_cfg_pkg::RST_DEV_GRADE
				| 8'({adc_cfg_pkg::GRADE_SPEED_CODE[1:0]} << adc_cfg_pkg::GRADE_SPEED_LSB); // RQ6
			adc_cfg_pkg::ADDR_TRANSFER: v = {7'h00, xfer}; // RQ7
			default: ;
		endcase
		return v;
	endfunction : read_value

	// frame sequencing: instruction, then data bytes until count or chip select
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_reg <= st_instr;
			bit_cnt_reg <= 5'd0;
			shift_reg <= 16'h0000;
			addr_reg <= 13'h0000;
			is_read_reg <= 1'b0;
			len_reg <= 2'b00;
			byte_cnt_reg <= 2'b00;
		end else if (csb_sync_reg) begin
			state_reg <= st_instr;
			bit_cnt_reg <= 5'd0;
			byte_cnt_reg <= 2'b00;
		end else if (sclk_rise) begin
			shift_reg <= shift_next;
			if (instr_done) begin
				state_reg <= st_data;
				bit_cnt_reg <= 5'd0;
				is_read_reg <= shift_next[adc_cfg_pkg::RW_BIT];
				len_reg <= shift_next[adc_cfg_pkg::LEN_LSB +: 2];
				addr_reg <= shift_next[12:0];
				byte_cnt_reg <= 2'b00;
			end else if (byte_done) begin
				bit_cnt_reg <= 5'd0;
				addr_reg <= addr_next;
				byte_cnt_reg <= byte_cnt_reg + 2'd1;
				if (len_reg != adc_cfg_pkg::LEN_STREAM && byte_cnt_reg == len_reg) begin
					state_reg <= st_instr;
				end
			end else begin
				bit_cnt_reg <= bit_cnt_reg + 5'd1;
			end
		end
	end

	// read data: loaded at each byte boundary, shifted out on falling edges
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			tx_reg <= 8'h00;
			sdio_out <= 1'b0;
			sdio_oe_n <= 1'b1;
		end else if (csb_sync_reg) begin
			sdio_oe_n <= 1'b1;
		end else if (instr_done) begin
			tx_reg <= read_value(shift_next[12:0], port_cfg_reg, transfer_reg,
				shadow_reg[shift_next[5:0]]);
		end else if (byte_done) begin
			tx_reg <= read_value(addr_next, port_cfg_reg, transfer_reg, shadow_reg[addr_next[5:0]]);
			if (len_reg != adc_cfg_pkg::LEN_STREAM && byte_cnt_reg == len_reg) begin
				sdio_oe_n <= 1'b1;
			end
		end else if (sclk_fall && state_reg == st_data && is_read_reg) begin
			sdio_oe_n <= 1'b0;
			sdio_out <= lsb_first ? tx_reg[0] : tx_reg[7];
			tx_reg <= lsb_first ? {1'b0, tx_reg[7:1]} : {tx_reg[6:0], 1'b0};
		end
	end

	// port configuration: written at once, soft reset bit requests a full reload
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			port_cfg_reg <= adc_cfg_pkg::RST_PORT_CFG; // RQ4
			soft_reset_reg <= 1'b0;
		end else if (soft_reset_reg) begin
			port_cfg_reg <= adc_cfg_pkg::RST_PORT_CFG; // RQ4
			soft_reset_reg <= 1'b0;
		end else if (wr_strobe && addr_reg == adc_cfg_pkg::ADDR_PORT_CFG) begin
			// either mirrored half sets both halves
			port_cfg_reg <= adc_cfg_pkg::PORT_FIXED_ONES
				| (8'(rx_byte[adc_cfg_pkg::PORT_LSB_HI] | rx_byte[adc_cfg_pkg::PORT_LSB_LO])
					* 8'h42); // RQ5
			soft_reset_reg <= rx_byte[adc_cfg_pkg::PORT_SRST_HI]
				| rx_byte[adc_cfg_pkg::PORT_SRST_LO]; // RQ5
		end
	end

	// transfer bit: set by command, cleared on the same clock edge as the copy
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			transfer_reg <= adc_cfg_pkg::RST_TRANSFER[0]; // RQ7
		end else if (soft_reset_reg) begin
			transfer_reg <= adc_cfg_pkg::RST_TRANSFER[0];
		end else if (wr_strobe && addr_reg == adc_cfg_pkg::ADDR_TRANSFER
			&& rx_byte == adc_cfg_pkg::TRANSFER_CMD) begin
			transfer_reg <= 1'b1; // RQ2
		end else begin
			transfer_reg <= 1'b0; // RQ3
		end
	end

	// holding copies take host writes
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			for (int i = 0; i < 64; i++) begin
				shadow_reg[i] <= bank_default(6'(i)); // RQ4
			end
		end else if (soft_reset_reg) begin
			for (int i = 0; i < 64; i++) begin
				shadow_reg[i] <= bank_default(6'(i));
			end
		end else if (wr_strobe && bank_mask(addr_reg) != 8'h00) begin
			shadow_reg[addr_reg[5:0]] <= rx_byte & bank_mask(addr_reg); // RQ1
		end
	end

	// active copies change only on reset, transfer or soft reset, all in the same cycle
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			for (int i = 0; i < 64; i++) begin
				active_reg[i] <= bank_default(6'(i)); // RQ4
			end
		end else if (soft_reset_reg) begin
			for (int i = 0; i < 64; i++) begin
				active_reg[i] <= bank_default(6'(i));
			end
		end else if (transfer_reg) begin
			for (int i = 0; i < 64; i++) begin
				active_reg[i] <= shadow_reg[i]; // RQ3
			end
		end
	end

	// settings seen by the converter, all from active copies
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			power_down <= 1'b0;
			clock_divide_ratio <= adc_cfg_pkg::DIV_BYPASS;
			divider_phase_delay <= 3'b000;
			stabilizer_active <= adc_cfg_pkg::RST_GLOBAL_CLOCK[0];
			user_pattern_single <= 1'b0;
			pn_long_reset <= 1'b0;
			pn_short_reset <= 1'b0;
			output_test_mode <= adc_cfg_pkg::TEST_OFF;
			offset_trim <= 6'h00;
			output_disable <= 1'b0;
			data_invert <= 1'b0;
			output_format <= adc_cfg_pkg::RST_OUT_FORMAT[1:0];
			drive_current_code <= 4'h0;
			output_data_clock_invert <= 1'b0;
			output_data_clock_delay_en <= 1'b0;
			output_data_clock_delay_code <= 5'h00;
			full_scale_code <= 5'h00;
			user_pattern_1 <= 16'h0000;
			user_pattern_2 <= 16'h0000;
			user_pattern_3 <= 16'h0000;
			user_pattern_4 <= 16'h0000;
			requant_enable <= 1'b0;
			requant_mode <= 3'b000;
			requant_tuning <= adc_cfg_pkg::RST_REQ_TUNING[5:0];
		end else begin
			power_down <= active_reg[adc_cfg_pkg::ADDR_POWER_MODE[5:0]][1:0]
				== adc_cfg_pkg::POWER_FULL_DOWN; // RQ8
			clock_divide_ratio <= active_reg[adc_cfg_pkg::ADDR_CLOCK_DIV[5:0]]
				[adc_cfg_pkg::DIV_RATIO_LSB +: 3];
			divider_phase_delay <= active_reg[adc_cfg_pkg::ADDR_CLOCK_DIV[5:0]]
				[adc_cfg_pkg::DIV_PHASE_LSB +: 3]; // RQ11
			stabilizer_active <= active_reg[adc_cfg_pkg::ADDR_GLOBAL_CLOCK[5:0]][0] // RQ9
				|| active_reg[adc_cfg_pkg::ADDR_CLOCK_DIV[5:0]][adc_cfg_pkg::DIV_RATIO_LSB +: 3]
					!= adc_cfg_pkg::DIV_BYPASS; // RQ10
			user_pattern_single <= active_reg[adc_cfg_pkg::ADDR_TEST_PATTERN[5:0]]
				[adc_cfg_pkg::TEST_SINGLE_BIT]; // RQ12
			pn_long_reset <= active_reg[adc_cfg_pkg::ADDR_TEST_PATTERN[5:0]]
				[adc_cfg_pkg::TEST_PN_LONG_BIT];
			pn_short_reset <= active_reg[adc_cfg_pkg::ADDR_TEST_PATTERN[5:0]]
				[adc_cfg_pkg::TEST_PN_SHORT_BIT];
			output_test_mode <= active_reg[adc_cfg_pkg::ADDR_TEST_PATTERN[5:0]]
				[adc_cfg_pkg::TEST_MODE_LSB +: 4]; // RQ13
			offset_trim <= active_reg[adc_cfg_pkg::ADDR_OFFSET_TRIM[5:0]][5:0]; // RQ14
			output_disable <= active_reg[adc_cfg_pkg::ADDR_OUT_FORMAT[5:0]]
				[adc_cfg_pkg::FMT_DISABLE_BIT]; // RQ15
			data_invert <= active_reg[adc_cfg_pkg::ADDR_OUT_FORMAT[5:0]]
				[adc_cfg_pkg::FMT_INVERT_BIT]; // RQ15
			output_format <= active_reg[adc_cfg_pkg::ADDR_OUT_FORMAT[5:0]][adc_cfg_pkg::FMT_LSB +: 2];
			drive_current_code <= active_reg[adc_cfg_pkg::ADDR_OUT_DRIVE[5:0]][3:0]; // RQ16
			output_data_clock_invert <= active_reg[adc_cfg_pkg::ADDR_OUT_CLK_PHASE[5:0]]
				[adc_cfg_pkg::CLK_INVERT_BIT];
			output_data_clock_delay_en <= active_reg[adc_cfg_pkg::ADDR_OUT_CLK_DELAY[5:0]]
				[adc_cfg_pkg::DLY_EN_BIT]; // RQ17
			output_data_clock_delay_code <= active_reg[adc_cfg_pkg::ADDR_OUT_CLK_DELAY[5:0]][4:0];
			full_scale_code <= active_reg[adc_cfg_pkg::ADDR_INPUT_SPAN[5:0]][4:0]; // RQ18
			user_pattern_1 <= {active_reg[6'h1a], active_reg[6'h19]};
			user_pattern_2 <= {active_reg[6'h1c], active_reg[6'h1b]};
			user_pattern_3 <= {active_reg[6'h1e], active_reg[6'h1d]};
			user_pattern_4 <= {active_reg[6'h20], active_reg[6'h1f]};
			requant_enable <= active_reg[adc_cfg_pkg::ADDR_REQ_CONTROL[5:0]]
				[adc_cfg_pkg::REQ_ENABLE_BIT];
			requant_mode <= active_reg[adc_cfg_pkg::ADDR_REQ_CONTROL[5:0]]
				[adc_cfg_pkg::REQ_MODE_LSB +: 3];
			requant_tuning <= active_reg[adc_cfg_pkg::ADDR_REQ_TUNING[5:0]][5:0];
		end
	end
endmodule : adc_config_register_map

// File: inc/adc_cfg_pkg.sv
// constants for the converter configuration register map and serial port
package adc_cfg_pkg;
	localparam logic [12:0] ADDR_PORT_CFG = 13'h0000;
	localparam logic [12:0] ADDR_DEV_ID = 13'h0001;
	localparam logic [12:0] ADDR_DEV_GRADE = 13'h0002;
	localparam logic [12:0] ADDR_POWER_MODE = 13'h0008;
	localparam logic [12:0] ADDR_GLOBAL_CLOCK = 13'h0009;
	localparam logic [12:0] ADDR_CLOCK_DIV = 13'h000b;
	localparam logic [12:0] ADDR_TEST_PATTERN = 13'h000d;
	localparam logic [12:0] ADDR_OFFSET_TRIM = 13'h0010;
	localparam logic [12:0] ADDR_OUT_FORMAT = 13'h0014;
	localparam logic [12:0] ADDR_OUT_DRIVE = 13'h0015;
	localparam logic [12:0] ADDR_OUT_CLK_PHASE = 13'h0016;
	localparam logic [12:0] ADDR_OUT_CLK_DELAY = 13'h0017;
	localparam logic [12:0] ADDR_INPUT_SPAN = 13'h0018;
	localparam logic [12:0] ADDR_PATTERN_FIRST = 13'h0019;
	localparam logic [12:0] ADDR_PATTERN_LAST = 13'h0020;
	localparam logic [12:0] ADDR_REQ_CONTROL = 13'h003c;
	localparam logic [12:0] ADDR_REQ_TUNING = 13'h003e;
	localparam logic [12:0] ADDR_TRANSFER = 13'h00ff;

	localparam logic [7:0] RST_PORT_CFG = 8'h18;
	localparam logic [7:0] RST_DEV_GRADE = 8'h00;
	localparam logic [7:0] RST_GLOBAL_CLOCK = 8'h01;
	localparam logic [7:0] RST_OUT_FORMAT = 8'h01;
	localparam logic [7:0] RST_REQ_TUNING = 8'h1c;
	localparam logic [7:0] RST_SHADOW = 8'h00;
	localparam logic [7:0] RST_TRANSFER = 8'h00;
	localparam logic [7:0] TRANSFER_CMD = 8'h01;

	// implemented bits of each writable shadowed register
	localparam logic [7:0] MASK_POWER_MODE = 8'h03;
	localparam logic [7:0] MASK_GLOBAL_CLOCK = 8'h01;
	localparam logic [7:0] MASK_CLOCK_DIV = 8'h3f;
	localparam logic [7:0] MASK_TEST_PATTERN = 8'hbf;
	localparam logic [7:0] MASK_OFFSET_TRIM = 8'h3f;
	localparam logic [7:0] MASK_OUT_FORMAT = 8'h17;
	localparam logic [7:0] MASK_OUT_DRIVE = 8'h0f;
	localparam logic [7:0] MASK_OUT_CLK_PHASE = 8'h80;
	localparam logic [7:0] MASK_OUT_CLK_DELAY = 8'h9f;
	localparam logic [7:0] MASK_INPUT_SPAN = 8'h1f;
	localparam logic [7:0] MASK_PATTERN = 8'hff;
	localparam logic [7:0] MASK_REQ_CONTROL = 8'h0f;
	localparam logic [7:0] MASK_REQ_TUNING = 8'h3f;

	// port configuration fields (mirrored nibbles)
	localparam int PORT_LSB_HI = 6;
	localparam int PORT_LSB_LO = 1;
	localparam int PORT_SRST_HI = 5;
	localparam int PORT_SRST_LO = 2;
	localparam logic [7:0] PORT_FIXED_ONES = 8'h18;
	localparam logic [7:0] PORT_WR_MASK = 8'h66;

	localparam logic [1:0] POWER_NORMAL = 2'b00;
	localparam logic [1:0] POWER_FULL_DOWN = 2'b01;
	localparam logic [2:0] DIV_BYPASS = 3'b000;
	localparam logic [3:0] TEST_OFF = 4'b0000;
	localparam logic [3:0] TEST_MIDSCALE_SHORT = 4'b0001;
	localparam logic [3:0] TEST_POS_FULL_SCALE = 4'b0010;

	// field positions in the shadowed bank
	localparam int DIV_RATIO_LSB = 0;
	localparam int DIV_PHASE_LSB = 3;
	localparam int TEST_MODE_LSB = 0;
	localparam int TEST_PN_SHORT_BIT = 4;
	localparam int TEST_PN_LONG_BIT = 5;
	localparam int TEST_SINGLE_BIT = 7;
	localparam int FMT_LSB = 0;
	localparam int FMT_INVERT_BIT = 2;
	localparam int FMT_DISABLE_BIT = 4;
	localparam int CLK_INVERT_BIT = 7;
	localparam int DLY_EN_BIT = 7;
	localparam int REQ_ENABLE_BIT = 0;
	localparam int REQ_MODE_LSB = 1;

	// serial frame
	localparam int INSTR_BITS = 16;
	localparam int RW_BIT = 15;
	localparam int LEN_LSB = 13;
	localparam logic [1:0] LEN_STREAM = 2'b11;
	localparam logic [2:0] GRADE_SPEED_CODE = 3'b000;
	localparam int GRADE_SPEED_LSB = 4;
endpackage : adc_cfg_pkg

// File: tb/adc_cfg_checker_sva.sv
// assertion checker for the configuration register bank ports
`timescale 1ns/100ps
module adc_cfg_checker (
	input wire logic clk,
	input wire logic nrst,
	input wire logic csb_n,
	input wire logic sclk,
	input wire logic sdio_out,
	input wire logic sdio_oe_n,
	input wire logic power_down,
	input wire logic [2:0] clock_divide_ratio,
	input wire logic [2:0] divider_phase_delay,
	input wire logic stabilizer_active,
	input wire logic [3:0] output_test_mode,
	input wire logic [5:0] offset_trim,
	input wire logic [1:0] output_format,
	input wire logic [5:0] requant_tuning,
	input wire logic [15:0] user_pattern_1
);
	logic [41:0] cfg;
	assign cfg = {power_down, clock_divide_ratio, divider_phase_delay, stabilizer_active,
		output_test_mode, offset_trim, output_format, requant_tuning, user_pattern_1};
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);
	AST_STAB_FORCED: assert property (
		clock_divide_ratio != 3'h0 |-> stabilizer_active) else $error("stabilizer off, divider set");
	AST_STAB_FALL: assert property (
		$fell(stabilizer_active) |-> clock_divide_ratio == 3'h0) else $error("stabilizer dropped");
	AST_RESET_DEFAULTS: assert property (disable iff (1'b0)
		!nrst |-> cfg == {8'h01, 4'h0, 6'h00, 2'h1, 6'h1c, 16'h0000} && sdio_oe_n)
		else $error("defaults not held in reset");
	AST_UPDATE_IN_FRAME: assert property (
		!$stable(cfg) |-> !csb_n) else $error("settings changed outside a frame");
	AST_UPDATE_ONCE: assert property (
		!$stable(cfg) |=> $stable(cfg) [*8]) else $error("settings not updated together");
	AST_IDLE_STABLE: assert property (
		csb_n [*4] |-> $stable(cfg)) else $error("settings changed while idle");
	AST_OE_READ: assert property (
		$fell(sdio_oe_n) |-> !csb_n && !sclk) else $error("data driven off a falling clock");
	AST_OE_RELEASE: assert property (
		csb_n [*4] |-> sdio_oe_n) else $error("data line driven while deselected");
	AST_SDIO_HOLD: assert property (
		(sclk && !csb_n) [*4] |-> $stable(sdio_out)) else $error("read bit changed while clock high");
endmodule : adc_cfg_checker

bind adc_config_register_map adc_cfg_checker chk (.*);

// File: tb/spi_host_model.sv
// serial-port host model driving the configuration register bank pins
`timescale 1ns/100ps
module spi_host_model (
	input wire logic clk,
	output logic sclk,
	output logic csb_n,
	output logic sdio_in,
	input wire logic sdio_out,
	input wire logic sdio_oe_n
);
	localparam int HALF = 5;
	// set by the bench once the device has been switched to lsb-first shifting
	logic lsb_mode = 1'b0;
	initial begin
		sclk = 1'b0;
		csb_n = 1'b1;
		sdio_in = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(negedge clk);
	endtask : tick
	// one-byte frame; a read bit the device did not drive comes back unknown
	task automatic frame(input logic rd, input logic [12:0] addr, input logic [7:0] wd,
		output logic [7:0] rdata);
		logic [23:0] bits;
		logic [23:0] fwd;
		fwd = {rd, 2'b00, addr, wd};
		bits = fwd;
		rdata = 8'h00;
		// lsb-first mode sends instruction and data each least significant bit first
		if (lsb_mode) begin
			for (int k = 0; k < 16; k++) begin
				bits[23 - k] = fwd[8 + k];
			end
			for (int k = 0; k < 8; k++) begin
				bits[7 - k] = fwd[k];
			end
		end
		csb_n = 1'b0;
		tick(HALF);
		for (int i = 23; i >= 0; i--) begin
			sclk = 1'b0;
			if (rd && i < 8) begin
				sdio_in = ~sdio_in;
			end else begin
				sdio_in = bits[i];
			end
			tick(HALF);
			if (rd && i < 8) begin
				rdata[i] = sdio_oe_n ? 1'bx : sdio_out;
			end
			sclk = 1'b1;
			tick(HALF);
		end
		if (lsb_mode) begin
			fwd[7:0] = rdata;
			for (int k = 0; k < 8; k++) begin
				rdata[k] = fwd[7 - k];
			end
		end
		tick(8);
		csb_n = 1'b1;
		sdio_in = ~sdio_in;
		tick(4);
		sclk = 1'b0;
		tick(HALF);
	endtask : frame
endmodule : spi_host_model

// File: tb/adc_config_register_map_tb.sv
// self-checking bench for the configuration register bank
`timescale 1ns/100ps
module adc_config_register_map_tb;
	localparam logic [7:0] ID_VAL = 8'h3c; // arbitrary identification value
	typedef struct packed {
		logic [12:0] a;
		logic [7:0] d;
		logic [7:0] dflt;
		logic [7:0] exp;
	} row_t;
	localparam row_t ROWS [21] = '{
		'{13'h008, 8'h01, 8'h00, 8'h01},
		'{13'h00b, 8'h32, 8'h00, 8'h32},
		'{13'h009, 8'h00, 8'h01, 8'h01},
		'{13'h00d, 8'hb2, 8'h00, 8'hb2},
		'{13'h00d, 8'h01, 8'hb2, 8'h01},
		'{13'h010, 8'h20, 8'h00, 8'h20},
		'{13'h014, 8'h14, 8'h01, 8'h14},
		'{13'h015, 8'h0f, 8'h00, 8'h0f},
		'{13'h016, 8'h80, 8'h00, 8'h80},
		'{13'h017, 8'h9f, 8'h00, 8'h9f},
		'{13'h018, 8'h0f, 8'h00, 8'h0f},
		'{13'h019, 8'ha5, 8'h00, 8'ha5},
		'{13'h01a, 8'h5a, 8'h00, 8'h5a},
		'{13'h01b, 8'h3c, 8'h00, 8'h3c},
		'{13'h01c, 8'hc3, 8'h00, 8'hc3},
		'{13'h01d, 8'h69, 8'h00, 8'h69},
		'{13'h01e, 8'h96, 8'h00, 8'h96},
		'{13'h01f, 8'h0f, 8'h00, 8'h0f},
		'{13'h020, 8'hf0, 8'h00, 8'hf0},
		'{13'h03c, 8'h03, 8'h00, 8'h03},
		'{13'h03e, 8'h05, 8'h1c, 8'h05}
	};
	// reset falls just after time zero so the asynchronous reset branch really runs
	logic clk = 1'b0, nrst = 1'b1, sclk, csb_n, sdio_in, sdio_out, sdio_oe_n;
	logic power_down, stabilizer_active, user_pattern_single, pn_long_reset, pn_short_reset;
	logic output_disable, data_invert, output_data_clock_invert, output_data_clock_delay_en;
	logic requant_enable;
	logic [1:0] output_format;
	logic [2:0] clock_divide_ratio, divider_phase_delay, requant_mode;
	logic [3:0] output_test_mode, drive_current_code;
	logic [4:0] output_data_clock_delay_code, full_scale_code;
	logic [5:0] offset_trim, requant_tuning;
	logic [15:0] user_pattern_1, user_pattern_2, user_pattern_3, user_pattern_4;
	logic [7:0] rv;
	int n_mismatch = 0, compares = 0;
	always #12.5 clk = ~clk;
	adc_config_register_map #(.DEVICE_ID(ID_VAL)) uut (.*);
	spi_host_model host (.*);
	// active setting of one address, rebuilt from the setting ports
	function automatic logic [7:0] seen(input logic [12:0] a);
		case (a)
			13'h008: seen = {7'h00, power_down};
			13'h009: seen = {7'h00, stabilizer_active};
			13'h00b: seen = {2'b00, divider_phase_delay, clock_divide_ratio};
			13'h00d: seen = {user_pattern_single, 1'b0, pn_long_reset, pn_short_reset, output_test_mode};
			13'h010: seen = {2'b00, offset_trim};
			13'h014: seen = {3'b000, output_disable, 1'b0, data_invert, output_format};
			13'h015: seen = {4'h0, drive_current_code};
			13'h016: seen = {output_data_clock_invert, 7'h00};
			13'h017: seen = {output_data_clock_delay_en, 2'b00, output_data_clock_delay_code};
			13'h018: seen = {3'b000, full_scale_code};
			13'h019: seen = user_pattern_1[7:0];
			13'h01a: seen = user_pattern_1[15:8];
			13'h01b: seen = user_pattern_2[7:0];
			13'h01c: seen = user_pattern_2[15:8];
			13'h01d: seen = user_pattern_3[7:0];
			13'h01e: seen = user_pattern_3[15:8];
			13'h01f: seen = user_pattern_4[7:0];
			13'h020: seen = user_pattern_4[15:8];
			13'h03c: seen = {4'h0, requant_mode, requant_enable};
			default: seen = {2'b00, requant_tuning};
		endcase
	endfunction : seen
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic wr(input logic [12:0] a, input logic [7:0] d);
		logic [7:0] unused;
		host.frame(1'b0, a, d, unused);
	endtask : wr
	task automatic rd(input logic [12:0] a, output logic [7:0] d);
		host.frame(1'b1, a, 8'h00, d);
	endtask : rd
	task automatic close_out;
		if (n_mismatch == 0 && compares > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : close_out
	initial begin
		#1 nrst = 1'b0;
		repeat (16) @(negedge clk);
		nrst = 1'b1;
		repeat (4) @(negedge clk);
		foreach (ROWS[i]) begin
			wr(ROWS[i].a, ROWS[i].d);
			chk("active before transfer", ROWS[i].dflt, seen(ROWS[i].a));
			rd(ROWS[i].a, rv);
			chk("holding copy", ROWS[i].d, rv);
			wr(13'h0ff, 8'h01);
			chk("active after transfer", ROWS[i].exp, seen(ROWS[i].a));
		end
		rd(13'h0ff, rv);
		chk("transfer bit", 8'h00, rv);
		rd(13'h001, rv);
		chk("identifier", ID_VAL, rv);
		wr(13'h002, 8'h30);
		rd(13'h002, rv);
		chk("grade", 8'h00, rv);
		rd(13'h000, rv);
		chk("port configuration", 8'h18, rv);
		rd(13'h013, rv);
		chk("unlisted address", 8'h00, rv);
		wr(13'h00b, 8'h00);
		wr(13'h0ff, 8'h02);
		chk("divider after refused transfer", 8'h32, seen(13'h00b));
		wr(13'h0ff, 8'h01);
		chk("stabilizer follows enable", 8'h00, seen(13'h009));
		// one mirrored half alone switches to lsb-first shifting
		wr(13'h000, 8'h02);
		host.lsb_mode = 1'b1;
		rd(13'h000, rv);
		chk("port lsb first", 8'h5a, rv);
		wr(13'h010, 8'h1d);
		rd(13'h010, rv);
		chk("holding lsb first", 8'h1d, rv);
		// soft reset sent lsb first also returns the port to msb-first shifting
		wr(13'h000, 8'h24);
		host.lsb_mode = 1'b0;
		chk("power after soft reset", 8'h00, seen(13'h008));
		chk("tuning after soft reset", 8'h1c, seen(13'h03e));
		chk("stabilizer after soft reset", 8'h01, seen(13'h009));
		rd(13'h000, rv);
		chk("port after soft reset", 8'h18, rv);
		wr(13'h008, 8'h01);
		wr(13'h0ff, 8'h01);
		chk("power down set", 8'h01, seen(13'h008));
		nrst = 1'b0;
		repeat (2) @(negedge clk);
		chk("format in reset", 8'h01, seen(13'h014));
		nrst = 1'b1;
		repeat (4) @(negedge clk);
		chk("power after reset", 8'h00, seen(13'h008));
		rd(13'h008, rv);
		chk("holding after reset", 8'h00, rv);
		close_out();
	end
	initial begin
		repeat (60000) @(posedge clk);
		n_mismatch++;
		close_out();
	end
endmodule : adc_config_register_map_tb
